/* File: smfl_pkg.sv */
// Constants and types for the shared memory firmware loader channel block
package smfl_pkg;
   // Register bus geometry
   localparam int          REG_AW          = 3;
   localparam int          REG_DW          = 8;
   // Register offsets
   localparam logic [2:0]  OFS_CONTROL     = 3'h0;
   localparam logic [2:0]  OFS_BASE_MATCH  = 3'h1;
   localparam logic [2:0]  OFS_WIN_SIZE    = 3'h2;
   localparam logic [2:0]  OFS_BANK        = 3'h3;
   localparam logic [2:0]  OFS_IRQ_LEVEL   = 3'h4;
   localparam logic [2:0]  OFS_PRODUCT_ID  = 3'h5;
   localparam logic [2:0]  OFS_IRQ_STATUS  = 3'h6;
   localparam logic [2:0]  OFS_IRQ_MASK    = 3'h7;
   // Control register fields
   localparam int          CTL_RUN_BIT     = 7;
   localparam int          CTL_MEM_EN_BIT  = 6;
   localparam int          CTL_INT_EN_BIT  = 5;
   localparam int          CTL_READY_BIT   = 2;
   // Interrupt status fields
   localparam int          IRQ_READY_BIT   = 0;
   localparam int          IRQ_BOOTED_BIT  = 1;
   localparam int          IRQ_W           = 2;
   // Reset values
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [3:0]  IRQ_LEVEL_RST   = 4'h0;
   // Product line value; arbitrary, not tied to any real part
   localparam logic [7:0]  PRODUCT_LINE_ID = 8'h5a;
   // Shared memory: 20-bit host address, 256K bytes of RAM, 16-bit words
   localparam int          HOST_AW         = 20;
   localparam int          RAM_BYTE_AW     = 18;
   localparam int          RAM_WORD_AW     = 17;
   localparam int          RAM_WORDS       = 131072;
   localparam int          BASE_SHIFT      = 12;
   localparam logic [2:0]  WIN_CODE_MAX    = 3'h5;
   localparam logic [17:0] WIN_MIN_BYTES   = 18'h02000;
   localparam logic [7:0]  WIN_MIN_BLOCKS  = 8'h02;
   // Start-up time before the channel reports its identity
   localparam int          STARTUP_MS      = 2000;
   localparam int          CLK_HZ          = 10000000;
   localparam int          STARTUP_CYC     = STARTUP_MS * (CLK_HZ / 1000);
   localparam int          STARTUP_W       = 25;
   // Channel life cycle
   typedef enum logic [1:0] {
      SMFL_BOOT = 2'b00,
      SMFL_IDLE = 2'b01,
      SMFL_RUN  = 2'b10
   } smfl_state_t;
endpackage

/* File: smfl_channel.sv */
// Channel register block and banked shared RAM for the firmware loader
`timescale 1ns/1ps
module smfl_channel
   import smfl_pkg::*;
#(
   parameter int STARTUP_CYCLES = STARTUP_CYC
) (
   // Clock and reset
   input  wire logic                I_CLK,
   input  wire logic                I_RST,
   // Register port
   input  wire logic [REG_AW-1:0]   I_REG_ADDR,
   input  wire logic [REG_DW-1:0]   I_REG_WDATA,
   input  wire logic                I_REG_WR,
   input  wire logic                I_REG_RD,
   output logic      [REG_DW-1:0]   O_REG_RDATA,
   // Host memory port
   input  wire logic [HOST_AW-1:0]  I_MEM_ADDR,
   input  wire logic [15:0]         I_MEM_WDATA,
   input  wire logic                I_MEM_WR,
   input  wire logic                I_MEM_RD,
   output logic      [15:0]         O_MEM_RDATA,
   output logic                     O_MEM_HIT,
   // Channel processor
   input  wire logic                I_FW_RUNNING,
   output logic                     O_PROC_RUN,
   // Host interrupt
   output logic      [3:0]          O_IRQ_LEVEL,
   output logic                     O_IRQ
);

   smfl_state_t            state_r;
   logic [STARTUP_W-1:0]   boot_cnt_r;
   logic                   run_r;
   logic                   mem_en_r;
   logic                   int_en_r;
   logic                   ready_r;
   logic [7:0]             base_r;
   logic [2:0]             win_r;
   logic [7:0]             bank_r;
   logic [3:0]             irq_level_r;
   logic [IRQ_W-1:0]       irq_sts_r;
   logic [IRQ_W-1:0]       irq_mask_r;
   logic [IRQ_W-1:0]       irq_evt;
   logic [15:0]            ram [0:RAM_WORDS-1];
   logic                   win_hit;
   logic [RAM_WORD_AW-1:0] ram_idx;
   logic                   wr_ctl;
   logic                   booted;
   logic                   ready_set;

   // Clamp window code; larger codes act as the largest window
   function automatic logic [2:0] win_code(input logic [2:0] c);
      return (c > WIN_CODE_MAX) ? WIN_CODE_MAX : c;
   endfunction

   // Window hit: compare 4K block number outside the window span
   function automatic logic in_window(input logic [HOST_AW-1:0] a,
                                      input logic [7:0] base, input logic [2:0] c);
      logic [7:0] m;
      m = (WIN_MIN_BLOCKS << win_code(c)) - 8'h01;
      return (a[HOST_AW-1:BASE_SHIFT] & ~m) == (base & ~m);
   endfunction

   // Word index: bank selects a window-sized slice of the RAM
   function automatic logic [RAM_WORD_AW-1:0] word_index(input logic [HOST_AW-1:0] a,
                                      input logic [7:0] bank, input logic [2:0] c);
      logic [RAM_BYTE_AW-1:0] span;
      logic [RAM_BYTE_AW-1:0] byte_idx;
      span     = WIN_MIN_BYTES << win_code(c);
      byte_idx = (a[RAM_BYTE_AW-1:0] & (span - 18'h00001))
                 | RAM_BYTE_AW'({10'h000, bank}
                   << (5'($clog2(WIN_MIN_BYTES)) + {2'b00, win_code(c)}));
      return byte_idx[RAM_BYTE_AW-1:1];
   endfunction

   assign wr_ctl    = I_REG_WR && (I_REG_ADDR == OFS_CONTROL);
   assign booted    = (state_r == SMFL_BOOT) && (boot_cnt_r >= STARTUP_W'(STARTUP_CYCLES - 1));
   assign ready_set = run_r && I_FW_RUNNING && !ready_r;
   assign irq_evt   = {booted, ready_set};

   // Start-up timer and channel life cycle
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state_r    <= SMFL_BOOT;
         boot_cnt_r <= '0;
      end else begin
         case (state_r)
            SMFL_BOOT: begin
               boot_cnt_r <= boot_cnt_r + STARTUP_W'(1);
               if (booted) begin
                  state_r <= SMFL_IDLE;
               end
            end
            SMFL_IDLE: begin
               if (run_r) begin
                  state_r <= SMFL_RUN;
               end
            end
            SMFL_RUN: begin
               if (!run_r) begin
                  state_r <= SMFL_IDLE;
               end
            end
            default: state_r <= SMFL_BOOT;
         endcase
      end
   end

   // Control bits; a write of zero stops processor and unmaps RAM
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         run_r    <= 1'b0;
         mem_en_r <= 1'b0;
         int_en_r <= 1'b0;
      end else if (wr_ctl) begin
         run_r    <= I_REG_WDATA[CTL_RUN_BIT] && (state_r != SMFL_BOOT);
         mem_en_r <= I_REG_WDATA[CTL_MEM_EN_BIT];
         int_en_r <= I_REG_WDATA[CTL_INT_EN_BIT];
      end
   end

   // Ready flag: set by running firmware, cleared when run drops; set wins
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ready_r <= 1'b0;
      end else if (ready_set) begin
         ready_r <= 1'b1;
      end else if (!run_r) begin
         ready_r <= 1'b0;
      end
   end

   // Window, bank and interrupt level setup registers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         base_r      <= RST_BYTE;
         win_r       <= 3'h0;
         bank_r      <= RST_BYTE;
         irq_level_r <= IRQ_LEVEL_RST;
      end else if (I_REG_WR) begin
         if (I_REG_ADDR == OFS_BASE_MATCH) begin
            base_r <= I_REG_WDATA;
         end else if (I_REG_ADDR == OFS_WIN_SIZE) begin
            win_r <= I_REG_WDATA[2:0];
         end else if (I_REG_ADDR == OFS_BANK) begin
            bank_r <= I_REG_WDATA;
         end else if (I_REG_ADDR == OFS_IRQ_LEVEL) begin
            irq_level_r <= I_REG_WDATA[3:0];
         end
      end
   end

   // Sticky interrupt status, write one to clear; new event beats the clear
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         irq_sts_r  <= '0;
         irq_mask_r <= '0;
      end else begin
         if (I_REG_WR && (I_REG_ADDR == OFS_IRQ_STATUS)) begin
            irq_sts_r <= (irq_sts_r & ~I_REG_WDATA[IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_sts_r <= irq_sts_r | irq_evt;
         end
         if (I_REG_WR && (I_REG_ADDR == OFS_IRQ_MASK)) begin
            irq_mask_r <= I_REG_WDATA[IRQ_W-1:0];
         end
      end
   end

   // Register read data, valid the cycle after the read strobe
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_REG_RDATA <= RST_BYTE;
      end else if (I_REG_RD) begin
         O_REG_RDATA <= RST_BYTE;
         if (I_REG_ADDR == OFS_CONTROL) begin
            O_REG_RDATA[CTL_RUN_BIT]    <= run_r;
            O_REG_RDATA[CTL_MEM_EN_BIT] <= mem_en_r;
            O_REG_RDATA[CTL_INT_EN_BIT] <= int_en_r;
            O_REG_RDATA[CTL_READY_BIT]  <= ready_r;
         end else if (I_REG_ADDR == OFS_BASE_MATCH) begin
            O_REG_RDATA <= base_r;
         end else if (I_REG_ADDR == OFS_WIN_SIZE) begin
            O_REG_RDATA[2:0] <= win_r;
         end else if (I_REG_ADDR == OFS_BANK) begin
            O_REG_RDATA <= bank_r;
         end else if (I_REG_ADDR == OFS_IRQ_LEVEL) begin
            O_REG_RDATA[3:0] <= irq_level_r;
         end else if (I_REG_ADDR == OFS_PRODUCT_ID) begin
            // Zero while still starting up, so the host sees an absent card
            O_REG_RDATA <= (state_r == SMFL_BOOT) ? RST_BYTE : PRODUCT_LINE_ID;
         end else if (I_REG_ADDR == OFS_IRQ_STATUS) begin
            O_REG_RDATA[IRQ_W-1:0] <= irq_sts_r;
         end else begin
            O_REG_RDATA[IRQ_W-1:0] <= irq_mask_r;
         end
      end
   end

   // Shared RAM decode; silent while disabled so a conflict probe sees others
   assign win_hit = mem_en_r && in_window(I_MEM_ADDR, base_r, win_r);
   assign ram_idx = word_index(I_MEM_ADDR, bank_r, win_r);

   // RAM array has no reset; contents are undefined until loaded
   always_ff @(posedge I_CLK) begin
      if (I_MEM_WR && win_hit) begin
         ram[ram_idx] <= I_MEM_WDATA;
      end
   end

   // RAM read data one cycle after the read strobe; hit flag one cycle after a read or write strobe
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_MEM_RDATA <= 16'h0000;
         O_MEM_HIT   <= 1'b0;
      end else begin
         O_MEM_HIT <= (I_MEM_RD || I_MEM_WR) && win_hit;
         if (I_MEM_RD && win_hit) begin
            O_MEM_RDATA <= ram[ram_idx];
         end
      end
   end

   assign O_PROC_RUN  = run_r;
   assign O_IRQ_LEVEL = irq_level_r;
   assign O_IRQ       = int_en_r && |(irq_sts_r & irq_mask_r);

   // Checks
   chk_id_boot: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_REG_RD && I_REG_ADDR == OFS_PRODUCT_ID && state_r == SMFL_BOOT)
      |=> O_REG_RDATA == RST_BYTE) else $error("identity visible during start-up");
   chk_id_ready: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_REG_RD && I_REG_ADDR == OFS_PRODUCT_ID && state_r != SMFL_BOOT)
      |=> O_REG_RDATA == PRODUCT_LINE_ID) else $error("wrong identity after start-up");
   chk_zero_disables: assert property (@(posedge I_CLK) disable iff (I_RST)
      (wr_ctl && I_REG_WDATA == RST_BYTE) |=> !O_PROC_RUN && !win_hit ##1 !O_MEM_HIT)
      else $error("control zero left channel active");
   chk_base_decode: assert property (@(posedge I_CLK) disable iff (I_RST)
      (win_hit) |-> I_MEM_ADDR[HOST_AW-1:HOST_AW-2] == base_r[7:6])
      else $error("hit outside programmed base");
   chk_small_window: assert property (@(posedge I_CLK) disable iff (I_RST)
      (win_hit && win_r == 3'h0) |-> I_MEM_ADDR[HOST_AW-1:BASE_SHIFT+1] == base_r[7:1])
      else $error("hit outside smallest window");
   chk_mem_only: assert property (@(posedge I_CLK) disable iff (I_RST)
      (wr_ctl && I_REG_WDATA == (8'h01 << CTL_MEM_EN_BIT)) |=> mem_en_r && !O_PROC_RUN)
      else $error("memory enable alone changed run state");
   chk_irq_gate: assert property (@(posedge I_CLK) disable iff (I_RST)
      O_IRQ |-> int_en_r && $past(|irq_sts_r) || $past(booted) || $past(ready_set))
      else $error("interrupt without enable or cause");
   chk_run_release: assert property (@(posedge I_CLK) disable iff (I_RST)
      (wr_ctl && I_REG_WDATA[CTL_RUN_BIT] && state_r != SMFL_BOOT) |=> O_PROC_RUN ##1
      state_r == SMFL_RUN) else $error("run bit did not start processor");
   chk_ready_flag: assert property (@(posedge I_CLK) disable iff (I_RST)
      (run_r && I_FW_RUNNING && !wr_ctl) |=> ready_r ##0 irq_sts_r[IRQ_READY_BIT] ||
      !$past(ready_set)) else $error("ready flag not raised");
   cov_boot:  cover property (@(posedge I_CLK) disable iff (I_RST) booted);
   cov_ready: cover property (@(posedge I_CLK) disable iff (I_RST) $rose(ready_r));
   cov_hit:   cover property (@(posedge I_CLK) disable iff (I_RST) I_MEM_RD && win_hit);
   cov_irq:   cover property (@(posedge I_CLK) disable iff (I_RST) $rose(O_IRQ));

endmodule

/* File: smfl_host_model.sv */
// Host processor model: register and memory bus master tasks
`timescale 1ns/1ps
module smfl_host_model
   import smfl_pkg::*;
(
   // Clock
   input  wire logic                i_clk,
   // Register bus
   output logic      [REG_AW-1:0]   o_reg_addr,
   output logic      [REG_DW-1:0]   o_reg_wdata,
   output logic                     o_reg_wr,
   output logic                     o_reg_rd,
   input  wire logic [REG_DW-1:0]   i_reg_rdata,
   // Memory bus
   output logic      [HOST_AW-1:0]  o_mem_addr,
   output logic      [15:0]         o_mem_wdata,
   output logic                     o_mem_wr,
   output logic                     o_mem_rd,
   input  wire logic [15:0]         i_mem_rdata,
   input  wire logic                i_mem_hit
);
   // Idle bus from time zero
   initial begin
      o_reg_addr  = '0;
      o_reg_wdata = '0;
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_mem_addr  = '0;
      o_mem_wdata = '0;
      o_mem_wr    = 1'b0;
      o_mem_rd    = 1'b0;
   end

   // One-cycle register strobe; read data taken in the following cycle
   task automatic reg_xfer(input logic wr, input logic [REG_AW-1:0] a,
                           input logic [REG_DW-1:0] d, output logic [REG_DW-1:0] q);
      @(posedge i_clk);
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      o_reg_wr    <= wr;
      o_reg_rd    <= !wr;
      @(posedge i_clk);
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      o_reg_wdata <= ~d;   // Released data never shows a stale value
      #1 q = i_reg_rdata;
   endtask

   // One-cycle memory strobe; hit and data seen the cycle after
   task automatic mem_xfer(input logic wr, input logic [HOST_AW-1:0] a, input logic [15:0] d,
                           output logic [15:0] q, output logic h);
      @(posedge i_clk);
      o_mem_addr  <= a;
      o_mem_wdata <= d;
      o_mem_wr    <= wr;
      o_mem_rd    <= !wr;
      @(posedge i_clk);
      o_mem_wr    <= 1'b0;
      o_mem_rd    <= 1'b0;
      o_mem_addr  <= ~a;   // Released lines toggle so a miss cannot look valid
      o_mem_wdata <= ~d;
      #1 q = i_mem_rdata;
      h = i_mem_hit;
   endtask
endmodule

/* File: smfl_channel_bench.sv */
// Self-checking bench for the firmware loader channel
`timescale 1ns/1ps
module smfl_channel_bench
   import smfl_pkg::*;
;
   localparam int           STARTUP_SIM = 16;
   localparam logic [19:0]  WIN_BASE    = 20'hd0000;
   logic               clk = 1'b0;
   logic               rst;
   logic [REG_AW-1:0]  reg_addr;
   logic [REG_DW-1:0]  reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [REG_DW-1:0]  reg_rdata;
   logic [HOST_AW-1:0] mem_addr;
   logic [15:0]        mem_wdata;
   logic               mem_wr;
   logic               mem_rd;
   logic [15:0]        mem_rdata;
   logic               mem_hit;
   logic               fw_running;
   logic               proc_run;
   logic [3:0]         irq_level;
   logic               irq;
   int                 err_count = 0;
   int                 samples_checked = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   smfl_channel #(.STARTUP_CYCLES(STARTUP_SIM)) smfl_channel_inst (
      .I_CLK(clk), .I_RST(rst), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
      .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata),
      .I_MEM_ADDR(mem_addr), .I_MEM_WDATA(mem_wdata), .I_MEM_WR(mem_wr),
      .I_MEM_RD(mem_rd), .O_MEM_RDATA(mem_rdata), .O_MEM_HIT(mem_hit),
      .I_FW_RUNNING(fw_running), .O_PROC_RUN(proc_run), .O_IRQ_LEVEL(irq_level), .O_IRQ(irq));

   smfl_host_model smfl_host_model_inst (
      .i_clk(clk), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr),
      .o_reg_rd(reg_rd), .i_reg_rdata(reg_rdata), .o_mem_addr(mem_addr),
      .o_mem_wdata(mem_wdata), .o_mem_wr(mem_wr), .o_mem_rd(mem_rd),
      .i_mem_rdata(mem_rdata), .i_mem_hit(mem_hit));

   // Bus shorthands and comparisons
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      smfl_host_model_inst.reg_xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] q);
      smfl_host_model_inst.reg_xfer(1'b0, a, 8'h00, q);
   endtask
   task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_pin(input string what, input logic exp, input logic got);
      cmp_val(what, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic close_out();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Identity is blank until start-up ends, then fixed and read-only
   task automatic check_identity();
      logic [7:0] q;
      rd(OFS_PRODUCT_ID, q);
      cmp_val("id early", 16'h0000, {8'h00, q});
      repeat (STARTUP_SIM) @(posedge clk);
      wr(OFS_PRODUCT_ID, 8'h00);
      rd(OFS_PRODUCT_ID, q);
      cmp_val("id ready", {8'h00, PRODUCT_LINE_ID}, {8'h00, q});
   endtask

   // Disabled channel must not answer the conflict probe
   task automatic conflict_probe();
      logic [15:0] saved;
      logic [15:0] d;
      logic        h;
      wr(OFS_CONTROL, 8'h00);
      cmp_pin("irq off in probe", 1'b0, irq);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE, 16'h0000, saved, h);
      smfl_host_model_inst.mem_xfer(1'b1, WIN_BASE, 16'haa55, d, h);
      cmp_pin("probe write hit", 1'b0, h);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE, 16'h0000, d, h);
      cmp_pin("probe read hit", 1'b0, h);
      cmp_val("probe readback", 16'h0000, d);
      if (d === 16'haa55) begin
         // Another device owns the range: give its word back and stop
         smfl_host_model_inst.mem_xfer(1'b1, WIN_BASE, saved, d, h);
         close_out();
      end
   endtask

   // Map an 8K window, fill two banks, verify and probe the edges
   task automatic ram_test();
      logic [15:0] d;
      logic        h;
      int          offs[3] = '{0, 1, 4095};
      wr(OFS_BASE_MATCH, WIN_BASE[19:12]);
      wr(OFS_WIN_SIZE, 8'h00);
      wr(OFS_CONTROL, 8'h40);
      cmp_pin("run while mapped", 1'b0, proc_run);
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < 2; b++) begin
            wr(OFS_BANK, 8'(b));
            foreach (offs[i]) begin
               smfl_host_model_inst.mem_xfer(p == 0, WIN_BASE + 20'(offs[i] * 2),
                                             ~16'(offs[i]) + 16'(b), d, h);
               cmp_pin("window hit", 1'b1, h);
               if (p == 1)
                  cmp_val("bank pattern", ~16'(offs[i]) + 16'(b), d);
            end
         end
      end
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE + 20'h02000, 16'h0000, d, h);
      cmp_pin("above window", 1'b0, h);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE - 20'h00002, 16'h0000, d, h);
      cmp_pin("below window", 1'b0, h);
      // 16K window: bank 0 now spans what the 8K test saw as banks 0 and 1
      wr(OFS_BANK, 8'h00);
      wr(OFS_WIN_SIZE, 8'h01);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE + 20'h02002, 16'h0000, d, h);
      cmp_pin("wide window hit", 1'b1, h);
      cmp_val("wide window data", 16'hffff, d);
   endtask

   // Load image, enable interrupt, start and wait for ready
   task automatic load_start();
      logic [7:0]  q;
      logic [15:0] d;
      logic        h;
      wr(OFS_BANK, 8'h00);
      for (int i = 0; i < 4; i++)
         smfl_host_model_inst.mem_xfer(1'b1, WIN_BASE + 20'(i * 2), 16'h1000 + 16'(i), d, h);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE + 20'h00006, 16'h0000, d, h);
      cmp_val("image tail", 16'h1003, d);
      wr(OFS_IRQ_LEVEL, 8'h05);
      cmp_val("irq level", 16'h0005, {12'h000, irq_level});
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_IRQ_STATUS, 8'h03);
      rd(OFS_CONTROL, q);
      wr(OFS_CONTROL, q | 8'h20);
      rd(OFS_CONTROL, q);
      wr(OFS_CONTROL, q | 8'h80);
      cmp_pin("processor released", 1'b1, proc_run);
      cmp_pin("irq before ready", 1'b0, irq);
      @(posedge clk);
      fw_running <= 1'b1;
      for (int n = 0; n < 20 && q[CTL_READY_BIT] !== 1'b1; n++)
         rd(OFS_CONTROL, q);
      cmp_pin("ready flag", 1'b1, q[CTL_READY_BIT]);
      if (q[CTL_READY_BIT] !== 1'b1)
         close_out();
      rd(OFS_IRQ_STATUS, q);
      cmp_val("ready event", 16'h0001, {8'h00, q});
      cmp_pin("irq raised", 1'b1, irq);
      wr(OFS_IRQ_MASK, 8'h00);
      cmp_pin("irq masked", 1'b0, irq);
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_CONTROL, 8'h60);
      @(posedge clk);
      fw_running <= 1'b0;
      wr(OFS_IRQ_STATUS, 8'h01);
      cmp_pin("irq cleared", 1'b0, irq);
   endtask

   // Silent firmware: ready never comes, host stops the channel
   task automatic start_timeout();
      logic [7:0]  q;
      logic [15:0] d;
      logic        h;
      wr(OFS_CONTROL, 8'hc4);   // Ready bit is read-only, the write must not set it
      for (int n = 0; n < 20; n++)
         rd(OFS_CONTROL, q);
      cmp_pin("no ready", 1'b0, q[CTL_READY_BIT]);
      wr(OFS_CONTROL, 8'h00);
      cmp_pin("processor halted", 1'b0, proc_run);
      smfl_host_model_inst.mem_xfer(1'b0, WIN_BASE, 16'h0000, d, h);
      cmp_pin("window closed", 1'b0, h);
   endtask

   // Reset for 20 cycles, then run every scenario
   initial begin
      rst        <= 1'b1;
      fw_running <= 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // One channel here; every further channel repeats this whole sequence
      check_identity();
      conflict_probe();
      ram_test();
      load_start();
      start_timeout();
      close_out();
   end
endmodule
